// *** msa_cmp.sv ***
// Purpose: Window comparison of one measurement against high and low limits
// Assumes: Value and thresholds share one format, 16 bits wide
// Notes:   IS_SIGNED selects two's complement compare

`timescale 1ns/100ps
`default_nettype none

module msa_cmp #(
    parameter bit IS_SIGNED = 1'b0
) (
    input  wire logic [15:0] value_i,
    input  wire logic [15:0] hi_thr_i,
    input  wire logic [15:0] lo_thr_i,
    output logic             above_o,
    output logic             below_o
);

    // ------------------------------------------------------------------
    // Compare
    // ------------------------------------------------------------------
    // Equal to a limit counts as inside, so both flags clear there
    always_comb begin
        if (IS_SIGNED) begin
            above_o = $signed(value_i) > $signed(hi_thr_i);
            below_o = $signed(value_i) < $signed(lo_thr_i);
        end else begin
            above_o = value_i > hi_thr_i;
            below_o = value_i < lo_thr_i;
        end
    end

endmodule : msa_cmp

`default_nettype wire

// *** msa_host.sv ***
// Purpose: Host model driving the byte register port like the serial slave
// Assumes: Strobes change 2 ns after the rising edge and last one cycle
// Notes:   Read data is taken one edge after the read strobe edge

`timescale 1ns/100ps
`default_nettype none

module msa_host (
    input  wire logic       clk_i,
    input  wire logic [7:0] reg_rdata_i,
    output logic      [7:0] reg_addr_o,
    output logic            reg_wr_o,
    output logic      [7:0] reg_wdata_o,
    output logic            reg_rd_o
);
    // ------------------------------------------------------------------
    // Bus cycles
    // ------------------------------------------------------------------
    // Idle values: strobes low, address and data parked on 00
    initial begin
        reg_addr_o  = 8'h00;
        reg_wr_o    = 1'b0;
        reg_wdata_o = 8'h00;
        reg_rd_o    = 1'b0;
    end

    // Writing zeros to the ready bits is how software arms a fresh check
    task automatic write_byte(input logic [7:0] addr, input logic [7:0] data);
        @(posedge clk_i);
        #2;
        reg_addr_o  = addr;
        reg_wdata_o = data;
        reg_wr_o    = 1'b1;
        @(posedge clk_i);
        #2;
        reg_wr_o    = 1'b0;
        reg_wdata_o = ~data; // Stale data must not look valid
    endtask : write_byte

    // Strobe is held across the taking edge, data read once it settled
    task automatic read_byte(input logic [7:0] addr, output logic [7:0] data);
        @(posedge clk_i);
        #2;
        reg_addr_o = addr;
        reg_rd_o   = 1'b1;
        @(posedge clk_i);
        #2;
        reg_rd_o   = 1'b0;
        data       = reg_rdata_i;
    endtask : read_byte
endmodule : msa_host

`default_nettype wire

// *** msa_pkg.sv ***
// Purpose: Constants for the monitor status and first alarm byte bank
// Assumes: Byte-wide register port driven by the serial management slave
// Notes:   Offsets are byte addresses in the lower memory page
//
// Summary of operation
// - Status bit 7 reads the live transmit-disable pin level.
// - Status bit 6 is a writable soft transmit-disable, ORed with the pin.
// - Status bit 5 reads the live level of general input one.
// - Status bit 4 reads the live rate-select input pin level.
// - Status bit 3 soft rate-select, ORed with pin to drive rate output.
// - Status bit 2 shows transmit-fault output: 0 driven low, 1 released.
// - Status bit 1 shows signal-loss output: 0 driven low, 1 released.
// - Status bit 0 is not-ready: 1 while supply is below the trip point.
// - Power-on clears both soft force bits; other status bits are live.
// - Ready bits 7:2 clear at power-on and set on each conversion done.
// - Software writes ready bits to zero; only new conversions set them.
// - Update bit 0 shows range of last monitor-three result, 1 coarse.
// - High-alarm flags set above high threshold, clear at or below it.
// - Low-alarm flags set below low threshold, clear at or above it.
// - Supply low alarm resets to 1, set below trip, cleared by measurement.
// - Temperature comparisons are signed two's complement.
// - Supply and monitor comparisons are unsigned 16-bit.

package msa_pkg;

    // ------------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------------
    localparam logic [7:0] MSA_OFS_STATUS = 8'h6E;
    localparam logic [7:0] MSA_OFS_UPDATE = 8'h6F;
    localparam logic [7:0] MSA_OFS_ALARM  = 8'h70;

    // ------------------------------------------------------------------
    // Status field positions
    // ------------------------------------------------------------------
    localparam int MSA_ST_TXOFF_PIN  = 7;
    localparam int MSA_ST_TXOFF_SOFT = 6;
    localparam int MSA_ST_GEN_IN1    = 5;
    localparam int MSA_ST_RATE_PIN   = 4;
    localparam int MSA_ST_RATE_SOFT  = 3;
    localparam int MSA_ST_TXFAULT    = 2;
    localparam int MSA_ST_SIG_LOSS   = 1;
    localparam int MSA_ST_NOT_READY  = 0;

    // ------------------------------------------------------------------
    // Update field positions
    // ------------------------------------------------------------------
    localparam int MSA_UP_TEMP  = 7;
    localparam int MSA_UP_VCC   = 6;
    localparam int MSA_UP_MONITOR_CHANNEL_ONE  = 5;
    localparam int MSA_UP_MONITOR_CHANNEL_FOUR  = 2;
    localparam int MSA_UP_RANGE = 0;
    localparam logic [7:0] MSA_UP_DONE_MASK = 8'hFC;

    // ------------------------------------------------------------------
    // Alarm field positions
    // ------------------------------------------------------------------
    localparam int MSA_AL_THERMAL_HIGH_ALARM = 7;
    localparam int MSA_AL_THERMAL_LOW_ALARM = 6;
    localparam int MSA_AL_SUPPLY_HIGH_ALARM  = 5;
    localparam int MSA_AL_SUPPLY_LOW_ALARM  = 4;
    localparam int MSA_AL_MONITOR_ONE_HIGH_ALARM = 3;
    localparam int MSA_AL_MONITOR_ONE_LOW_ALARM = 2;
    localparam int MSA_AL_MONITOR_TWO_HIGH_ALARM = 1;
    localparam int MSA_AL_MONITOR_TWO_LOW_ALARM = 0;

    // ------------------------------------------------------------------
    // Values after reset, and the read value of unmapped offsets
    // ------------------------------------------------------------------
    localparam logic [1:0]  MSA_SOFT_RST     = 2'h0;
    localparam logic [7:0]  MSA_UPDATE_RST   = 8'h00;
    localparam logic [7:0]  MSA_ALARM_RST    = 8'h10;
    localparam logic [7:0]  MSA_UNMAPPED     = 8'h00;
    localparam logic [15:0] MSA_THERMAL_HIGH_ALARM_DFLT = 16'h7FFF;
    localparam logic [15:0] MSA_ANA_HI_DFLT  = 16'hFFFF;

    // Clock period in nanoseconds, for reference only
    localparam int MSA_CLK_PERIOD_NS = 20;

endpackage : msa_pkg

// *** msa_regs.sv ***
// Purpose: Pin status, conversion-ready and primary alarm byte registers
// Assumes: Byte register port from the serial slave on clk_i; pins async
// Notes:   Read data appears one clock after the read strobe

`timescale 1ns/100ps
`default_nettype none

module msa_regs
    import msa_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        rst_n_i,
    // Register port
    input  wire logic [7:0]  reg_addr_i,
    input  wire logic        reg_wr_i,
    input  wire logic [7:0]  reg_wdata_i,
    input  wire logic        reg_rd_i,
    output logic      [7:0]  reg_rdata_o,
    // Device pins, asynchronous
    input  wire logic        tx_off_pin_i,
    input  wire logic        general_input_one_i,
    input  wire logic        rate_select_input_i,
    input  wire logic        supply_below_trip_i,
    // Driven state of open-drain outputs, from on-chip logic
    input  wire logic        transmit_fault_released_i,
    input  wire logic        signal_loss_released_i,
    // Conversion results, one-cycle done pulses
    input  wire logic        temp_done_i,
    input  wire logic        vcc_done_i,
    input  wire logic [3:0]  mon_done_i,
    input  wire logic        monitor_channel_three_coarse_i,
    input  wire logic [15:0] temp_value_i,
    input  wire logic [15:0] vcc_value_i,
    input  wire logic [15:0] monitor_channel_one_value_i,
    input  wire logic [15:0] monitor_channel_two_value_i,
    // Thresholds from threshold memory
    input  wire logic [15:0] thermal_high_alarm_thr_i,
    input  wire logic [15:0] thermal_low_alarm_thr_i,
    input  wire logic [15:0] supply_high_alarm_thr_i,
    input  wire logic [15:0] supply_low_alarm_thr_i,
    input  wire logic [15:0] monitor_one_high_alarm_thr_i,
    input  wire logic [15:0] monitor_one_low_alarm_thr_i,
    input  wire logic [15:0] monitor_two_high_alarm_thr_i,
    input  wire logic [15:0] monitor_two_low_alarm_thr_i,
    // Merged controls and synchronised not-ready flag
    output logic             tx_disable_o,
    output logic             rate_select_output_o,
    output logic             not_ready_flag_o
);

    // ------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------
    logic [3:0] pin_meta;
    logic [3:0] pin_sync;
    logic [3:0] next_pin_meta;
    logic [3:0] next_pin_sync;

    // Order: supply-low, rate pin, general input, tx-off pin
    always_comb begin
        next_pin_meta = {supply_below_trip_i, rate_select_input_i,
                         general_input_one_i, tx_off_pin_i};
        next_pin_sync = pin_meta;
    end

    // Supply stage resets high so the part reports not-ready at power-on
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pin_meta <= 4'h8;
            pin_sync <= 4'h8;
        end else begin
            pin_meta <= next_pin_meta;
            pin_sync <= next_pin_sync;
        end
    end

    logic tx_off_pin_state;
    logic gen_input_one_state;
    logic rate_pin_state;
    logic supply_low_s;

    assign tx_off_pin_state    = pin_sync[0];
    assign gen_input_one_state = pin_sync[1];
    assign rate_pin_state      = pin_sync[2];
    assign supply_low_s        = pin_sync[3];

    // ------------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------------
    logic hit_status;
    logic hit_update;
    logic hit_alarm;

    assign hit_status = reg_addr_i == MSA_OFS_STATUS;
    assign hit_update = reg_addr_i == MSA_OFS_UPDATE;
    assign hit_alarm  = reg_addr_i == MSA_OFS_ALARM;

    // ------------------------------------------------------------------
    // Soft force bits
    // ------------------------------------------------------------------
    logic tx_off_soft_force;
    logic rate_soft_force;
    logic next_tx_off_soft_force;
    logic next_rate_soft_force;

    // Only the two writable positions take data; the rest ignore writes
    always_comb begin
        next_tx_off_soft_force = tx_off_soft_force;
        next_rate_soft_force   = rate_soft_force;
        if (reg_wr_i && hit_status) begin
            next_tx_off_soft_force = reg_wdata_i[MSA_ST_TXOFF_SOFT];
            next_rate_soft_force   = reg_wdata_i[MSA_ST_RATE_SOFT];
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            tx_off_soft_force <= MSA_SOFT_RST[1];
            rate_soft_force   <= MSA_SOFT_RST[0];
        end else begin
            tx_off_soft_force <= next_tx_off_soft_force;
            rate_soft_force   <= next_rate_soft_force;
        end
    end

    // Merged outputs; the pin path adds two cycles of synchroniser delay
    assign tx_disable_o         = tx_off_pin_state | tx_off_soft_force;
    assign rate_select_output_o = rate_pin_state | rate_soft_force;
    assign not_ready_flag_o     = supply_low_s;

    // ------------------------------------------------------------------
    // Comparators
    // ------------------------------------------------------------------
    logic [3:0] above;
    logic [3:0] below;

    msa_cmp #(.IS_SIGNED(1'b1)) u_cmp_temp (
        .value_i  (temp_value_i),
        .hi_thr_i (thermal_high_alarm_thr_i),
        .lo_thr_i (thermal_low_alarm_thr_i),
        .above_o  (above[0]),
        .below_o  (below[0])
    );

    msa_cmp #(.IS_SIGNED(1'b0)) u_cmp_vcc (
        .value_i  (vcc_value_i),
        .hi_thr_i (supply_high_alarm_thr_i),
        .lo_thr_i (supply_low_alarm_thr_i),
        .above_o  (above[1]),
        .below_o  (below[1])
    );

    msa_cmp #(.IS_SIGNED(1'b0)) u_cmp_monitor_channel_one (
        .value_i  (monitor_channel_one_value_i),
        .hi_thr_i (monitor_one_high_alarm_thr_i),
        .lo_thr_i (monitor_one_low_alarm_thr_i),
        .above_o  (above[2]),
        .below_o  (below[2])
    );

    msa_cmp #(.IS_SIGNED(1'b0)) u_cmp_monitor_channel_two (
        .value_i  (monitor_channel_two_value_i),
        .hi_thr_i (monitor_two_high_alarm_thr_i),
        .lo_thr_i (monitor_two_low_alarm_thr_i),
        .above_o  (above[3]),
        .below_o  (below[3])
    );

    // ------------------------------------------------------------------
    // Update and alarm bytes
    // ------------------------------------------------------------------
    logic [7:0] update_reg;
    logic [7:0] alarm_reg;
    logic [7:0] next_update_reg;
    logic [7:0] next_alarm_reg;
    logic [7:0] done_vec;

    // Monitor one sits at bit 5 and monitor four at bit 2, so the pulses go in reversed
    assign done_vec = {temp_done_i, vcc_done_i, mon_done_i[0], mon_done_i[1],
                       mon_done_i[2], mon_done_i[3], 2'b00};

    // Software may only clear ready bits; a completion in the same cycle wins
    always_comb begin
        next_update_reg = update_reg;
        if (reg_wr_i && hit_update) begin
            next_update_reg = update_reg & (reg_wdata_i | ~MSA_UP_DONE_MASK);
        end
        next_update_reg = next_update_reg | done_vec;
        if (mon_done_i[2]) begin
            next_update_reg[MSA_UP_RANGE] = monitor_channel_three_coarse_i;
        end
        next_update_reg[1] = 1'b0;

        // Flags follow the latest completed measurement; supply low is also set by the trip input
        next_alarm_reg = alarm_reg;
        if (temp_done_i) begin
            next_alarm_reg[MSA_AL_THERMAL_HIGH_ALARM] = above[0];
            next_alarm_reg[MSA_AL_THERMAL_LOW_ALARM] = below[0];
        end
        if (vcc_done_i) begin
            next_alarm_reg[MSA_AL_SUPPLY_HIGH_ALARM] = above[1];
            next_alarm_reg[MSA_AL_SUPPLY_LOW_ALARM] = below[1];
        end
        if (mon_done_i[0]) begin
            next_alarm_reg[MSA_AL_MONITOR_ONE_HIGH_ALARM] = above[2];
            next_alarm_reg[MSA_AL_MONITOR_ONE_LOW_ALARM] = below[2];
        end
        if (mon_done_i[1]) begin
            next_alarm_reg[MSA_AL_MONITOR_TWO_HIGH_ALARM] = above[3];
            next_alarm_reg[MSA_AL_MONITOR_TWO_LOW_ALARM] = below[3];
        end
        // Supply under the trip point overrides any measurement result
        if (supply_low_s) begin
            next_alarm_reg[MSA_AL_SUPPLY_LOW_ALARM] = 1'b1;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            update_reg <= MSA_UPDATE_RST;
            alarm_reg  <= MSA_ALARM_RST;
        end else begin
            update_reg <= next_update_reg;
            alarm_reg  <= next_alarm_reg;
        end
    end

    // ------------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------------
    logic [7:0] status_view;
    logic [7:0] next_rdata;

    // Status is assembled live at read time
    always_comb begin
        status_view = 8'h00;
        status_view[MSA_ST_TXOFF_PIN]  = tx_off_pin_state;
        status_view[MSA_ST_TXOFF_SOFT] = tx_off_soft_force;
        status_view[MSA_ST_GEN_IN1]    = gen_input_one_state;
        status_view[MSA_ST_RATE_PIN]   = rate_pin_state;
        status_view[MSA_ST_RATE_SOFT]  = rate_soft_force;
        status_view[MSA_ST_TXFAULT]    = transmit_fault_released_i;
        status_view[MSA_ST_SIG_LOSS]   = signal_loss_released_i;
        status_view[MSA_ST_NOT_READY]  = supply_low_s;

        next_rdata = reg_rdata_o;
        if (reg_rd_i) begin
            if (hit_status) begin
                next_rdata = status_view;
            end else if (hit_update) begin
                next_rdata = update_reg;
            end else if (hit_alarm) begin
                next_rdata = alarm_reg;
            end else begin
                next_rdata = MSA_UNMAPPED;
            end
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            reg_rdata_o <= 8'h00;
        end else begin
            reg_rdata_o <= next_rdata;
        end
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    sequence read_status_s;
        reg_rd_i && hit_status;
    endsequence

    sequence force_tx_s;
        reg_wr_i && hit_status && reg_wdata_i[MSA_ST_TXOFF_SOFT];
    endsequence

    sequence clear_temp_rdy_s;
        reg_wr_i && hit_update && !reg_wdata_i[MSA_UP_TEMP] && !temp_done_i;
    endsequence

    txoff_status_a: assert property (
        @(posedge clk_i) disable iff (!rst_n_i)
        read_status_s |=> reg_rdata_o[MSA_ST_TXOFF_PIN] == $past(tx_off_pin_i, 3))
        else $error("status bit 7 does not follow transmit-disable pin");

    soft_force_a: assert property (
        @(posedge clk_i) disable iff (!rst_n_i)
        force_tx_s ##1 (!reg_wr_i || !hit_status) [*2] |-> tx_disable_o)
        else $error("soft transmit-disable did not force output");

    gen_input_a: assert property (
        @(posedge clk_i) disable iff (!rst_n_i)
        read_status_s |=> reg_rdata_o[MSA_ST_GEN_IN1] == $past(general_input_one_i, 3))
        else $error("status bit 5 does not follow general input one");

    rate_merge_a: assert property (
        @(posedge clk_i) disable iff (!rst_n_i)
        rate_select_output_o == ($past(rate_select_input_i, 2) | rate_soft_force))
        else $error("rate output is not pin OR soft bit");

    ready_set_a: assert property (
        @(posedge clk_i) disable iff (!rst_n_i)
        temp_done_i |=> update_reg[MSA_UP_TEMP])
        else $error("temperature ready bit not set after conversion");

    ready_clear_a: assert property (
        @(posedge clk_i) disable iff (!rst_n_i)
        clear_temp_rdy_s ##1 !temp_done_i |=> !update_reg[MSA_UP_TEMP])
        else $error("temperature ready bit rose without a conversion");

    range_flag_a: assert property (
        @(posedge clk_i) disable iff (!rst_n_i)
        mon_done_i[2] |=> update_reg[MSA_UP_RANGE] == $past(monitor_channel_three_coarse_i))
        else $error("range flag does not match monitor-three conversion");

    temp_high_a: assert property (
        @(posedge clk_i) disable iff (!rst_n_i)
        temp_done_i |=> alarm_reg[MSA_AL_THERMAL_HIGH_ALARM] ==
            ($signed($past(temp_value_i)) > $signed($past(thermal_high_alarm_thr_i))))
        else $error("temperature high alarm wrong after measurement");

    monitor_channel_one_low_a: assert property (
        @(posedge clk_i) disable iff (!rst_n_i)
        mon_done_i[0] |=> alarm_reg[MSA_AL_MONITOR_ONE_LOW_ALARM] ==
            ($past(monitor_channel_one_value_i) < $past(monitor_one_low_alarm_thr_i)))
        else $error("monitor one low alarm wrong after measurement");

    supply_low_a: assert property (
        @(posedge clk_i) disable iff (!rst_n_i)
        supply_low_s |=> alarm_reg[MSA_AL_SUPPLY_LOW_ALARM])
        else $error("supply low alarm clear while under trip point");

    reserved_zero_a: assert property (
        @(posedge clk_i) disable iff (!rst_n_i)
        reg_rd_i && hit_update |=> reg_rdata_o[1] == 1'b0)
        else $error("reserved update bit read as one");

endmodule : msa_regs

`default_nettype wire

// *** tb_monitor_status_alarm_regs.sv ***
// Purpose: Self-checking bench for the status, update and alarm bytes
// Assumes: Inputs change 2 ns after the rising edge
// Notes:   Pins pass two sync flops, so reads wait a few cycles after a change

`timescale 1ns/100ps
`default_nettype none

module tb_monitor_status_alarm_regs
    import msa_pkg::*;
;
    logic        clk;
    logic        rst_n;
    logic [5:0]  pins;   // tx_off, gen_in1, rate, fault_rel, loss_rel, supply_low
    logic [5:0]  done;   // temp, vcc, monitor_channel_four..monitor_channel_one
    logic        coarse;
    logic [15:0] meas [12]; // t,th,tl, v,vh,vl, m1,m1h,m1l, m2,m2h,m2l
    logic [7:0]  addr, wdata, rdata, rd_val, exp_st;
    logic        wr, rd, tx_dis, rate_out, nrdy;
    int          err_count = 0;
    int          check_count = 0;
    int          cycles = 0;

    msa_regs i_msa_regs (.clk_i(clk), .rst_n_i(rst_n), .reg_addr_i(addr), .reg_wr_i(wr),
        .reg_wdata_i(wdata), .reg_rd_i(rd), .reg_rdata_o(rdata), .tx_off_pin_i(pins[5]),
        .general_input_one_i(pins[4]), .rate_select_input_i(pins[3]),
        .supply_below_trip_i(pins[0]), .transmit_fault_released_i(pins[2]),
        .signal_loss_released_i(pins[1]), .temp_done_i(done[5]), .vcc_done_i(done[4]),
        .mon_done_i(done[3:0]), .monitor_channel_three_coarse_i(coarse), .temp_value_i(meas[0]),
        .vcc_value_i(meas[3]), .monitor_channel_one_value_i(meas[6]), .monitor_channel_two_value_i(meas[9]),
        .thermal_high_alarm_thr_i(meas[1]), .thermal_low_alarm_thr_i(meas[2]), .supply_high_alarm_thr_i(meas[4]),
        .supply_low_alarm_thr_i(meas[5]), .monitor_one_high_alarm_thr_i(meas[7]), .monitor_one_low_alarm_thr_i(meas[8]),
        .monitor_two_high_alarm_thr_i(meas[10]), .monitor_two_low_alarm_thr_i(meas[11]), .tx_disable_o(tx_dis),
        .rate_select_output_o(rate_out), .not_ready_flag_o(nrdy));

    msa_host i_msa_host (.clk_i(clk), .reg_rdata_i(rdata), .reg_addr_o(addr),
        .reg_wr_o(wr), .reg_wdata_o(wdata), .reg_rd_o(rd));

    // ------------------------------------------------------------------
    // Clock, watchdog and helpers
    // ------------------------------------------------------------------
    initial clk = 1'b0;
    always #10 clk = ~clk;

    // Whole run is about 125 cycles; the 5000-cycle ceiling leaves wide margin
    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            err_count++;
            $display("Timeout after %0d cycles", cycles);
            stop_test();
        end
    end

    task automatic chk8(input string name, input logic [7:0] exp, input logic [7:0] got);
        check_count++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask : chk8

    task automatic chk1(input string name, input logic exp, input logic got);
        check_count++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED %s expected %b seen %b", name, exp, got);
        end
    endtask : chk1

    task automatic rd_chk(input string name, input logic [7:0] a, input logic [7:0] exp);
        i_msa_host.read_byte(a, rd_val);
        chk8(name, exp, rd_val);
    endtask : rd_chk

    // Two sync flops plus margin before pins are looked at
    task automatic settle();
        repeat (4) @(posedge clk);
        #2;
    endtask : settle

    // One-cycle done pulse; values are already held on the inputs
    task automatic pulse(input logic [5:0] d, input logic c);
        @(posedge clk);
        #2;
        done   = d;
        coarse = c;
        @(posedge clk);
        #2;
        done   = 6'h00;
        coarse = ~c;
    endtask : pulse

    task automatic stop_test();
        $display("Comparisons %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : stop_test

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        rst_n  = 1'b0;
        pins   = 6'h01;
        done   = 6'h00;
        coarse = 1'b0;
        meas   = '{default: 16'h0000};
        repeat (8) @(posedge clk);
        #2;
        chk1("not_ready_reset", 1'b1, nrdy);
        chk1("tx_disable_reset", 1'b0, tx_dis);
        rst_n = 1'b1;
        pins  = 6'h00;
        settle();
        rd_chk("update_reset", MSA_OFS_UPDATE, 8'h00);
        rd_chk("alarm_reset", MSA_OFS_ALARM, 8'h10);
        rd_chk("status_reset", MSA_OFS_STATUS, 8'h00);
        // Each pin alone, then all at once
        for (int i = 0; i < 7; i++) begin
            pins = (i == 6) ? 6'h3F : 6'(1 << i);
            settle();
            exp_st = {pins[5], 1'b0, pins[4:3], 1'b0, pins[2:0]};
            rd_chk("status_pins", MSA_OFS_STATUS, exp_st);
            chk1("status_fault", pins[2], rd_val[MSA_ST_TXFAULT]);
            chk1("status_loss", pins[1], rd_val[MSA_ST_SIG_LOSS]);
            chk1("tx_disable", pins[5], tx_dis);
            chk1("rate_out", pins[3], rate_out);
            chk1("not_ready", pins[0], nrdy);
        end
        pins = 6'h00;
        settle();
        i_msa_host.write_byte(MSA_OFS_STATUS, 8'hFF);
        rd_chk("status_soft", MSA_OFS_STATUS, 8'h48);
        chk1("tx_disable_soft", 1'b1, tx_dis);
        chk1("rate_out_soft", 1'b1, rate_out);
        i_msa_host.write_byte(MSA_OFS_STATUS, 8'h00);
        rd_chk("status_cleared", MSA_OFS_STATUS, 8'h00);
        i_msa_host.write_byte(MSA_OFS_ALARM, 8'h00);
        rd_chk("alarm_readonly", MSA_OFS_ALARM, 8'h10);
        i_msa_host.write_byte(8'h71, 8'hFF);
        rd_chk("unmapped", 8'h71, 8'h00);
        // Case A: high on temp and vcc, low on monitor_channel_one, monitor_channel_two equal to both
        meas = '{16'h0100, 16'h00FF, 16'h0000, 16'h8000, 16'h7FFF, 16'h0000,
                 16'h0010, 16'hFFFF, 16'h0020, 16'h0020, 16'h0020, 16'h0020};
        pulse(6'h3F, 1'b1);
        rd_chk("update_all", MSA_OFS_UPDATE, 8'hFD);
        rd_chk("alarm_a", MSA_OFS_ALARM, 8'hA4);
        i_msa_host.write_byte(MSA_OFS_UPDATE, 8'h00);
        rd_chk("update_clear", MSA_OFS_UPDATE, 8'h01);
        i_msa_host.write_byte(MSA_OFS_UPDATE, 8'hFF);
        rd_chk("update_no_set", MSA_OFS_UPDATE, 8'h01);
        // Case B: negative temp below zero only counts when signed
        meas = '{16'hFF00, 16'h7FFF, 16'h0000, 16'hFFFF, 16'hFFFF, 16'h0001,
                 16'h0020, 16'h0020, 16'h0020, 16'h8001, 16'h8000, 16'h0000};
        pulse(6'h33, 1'b0);
        rd_chk("update_fresh", MSA_OFS_UPDATE, 8'hF1);
        rd_chk("alarm_b", MSA_OFS_ALARM, 8'h42);
        pins = 6'h01;
        settle();
        rd_chk("alarm_supply_low", MSA_OFS_ALARM, 8'h52);
        pins = 6'h00;
        settle();
        rd_chk("alarm_supply_hold", MSA_OFS_ALARM, 8'h52);
        pulse(6'h04, 1'b0);
        rd_chk("update_fine", MSA_OFS_UPDATE, 8'hF8);
        // Case C: 8000h is most negative, so no temp high alarm
        meas = '{16'h8000, 16'h7FFF, 16'h8000, 16'h0001, 16'hFFFF, 16'h0002,
                 16'hFFFF, 16'hFFFE, 16'h0000, 16'h0000, 16'hFFFF, 16'h0001};
        pulse(6'h33, 1'b0);
        rd_chk("alarm_c", MSA_OFS_ALARM, 8'h19);
        meas[3] = 16'h0002;
        pulse(6'h10, 1'b0);
        rd_chk("alarm_vcc_ok", MSA_OFS_ALARM, 8'h09);
        stop_test();
    end
endmodule : tb_monitor_status_alarm_regs

`default_nettype wire
